/* File: clpm_pkg.sv */
package clpm_pkg;

	// ==================================================
	// loop message framing
	localparam int ADDR_W = 8;
	localparam int KIND_W = 4;
	localparam int DATA_W = 8;
	localparam int CRC_W = 8;
	localparam int PAY_W = KIND_W + ADDR_W + DATA_W;
	// start bit, payload, crc, stop bit
	localparam int FRM_W = PAY_W + CRC_W + 2;
	localparam int MAX_UNITS = 240;
	localparam logic [1:0] MAX_RETRY = 2'h3;

	// ==================================================
	// selectable loop baud rates, in bits per second
	localparam int BAUD_110 = 110;
	localparam int BAUD_300 = 300;
	localparam int BAUD_600 = 600;
	localparam int BAUD_1200 = 1200;
	localparam int BAUD_2400 = 2400;

	// ==================================================
	// message kinds, master to unit then unit to master
	localparam logic [3:0] K_POLL = 4'h1;
	localparam logic [3:0] K_ACK = 4'h2;
	localparam logic [3:0] K_CMD = 4'h3;
	localparam logic [3:0] K_PARAM = 4'h4;
	localparam logic [3:0] K_LOOPOFF = 4'h5;
	localparam logic [3:0] K_NONEW = 4'h8;
	localparam logic [3:0] K_REPORT = 4'h9;
	localparam logic [3:0] K_TYPE = 4'ha;
	// parameter id carried in data[7:4] of a parameter write
	localparam logic [3:0] PARAM_ADDR_ID = 4'h0;

	// ==================================================
	// register offsets
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_RANGE = 8'h04;
	localparam logic [7:0] OFF_TMO = 8'h08;
	localparam logic [7:0] OFF_CMD = 8'h0c;
	localparam logic [7:0] OFF_STAT = 8'h10;
	localparam logic [7:0] OFF_SEL = 8'h14;
	localparam logic [7:0] OFF_UNIT = 8'h18;

	// field positions
	localparam int CTRL_EN = 0;
	localparam int CTRL_CLR = 1;
	localparam int CTRL_BAUD = 2;
	localparam int CTRL_RESTART = 5;
	localparam int CMD_PARAM = 16;
	localparam int STAT_BLK = 19;

	// reset values and quiet time before recovery
	localparam logic [15:0] RST_TMO = 16'h0040;
	localparam logic [7:0] RST_LO = 8'h01;
	localparam logic [7:0] RST_HI = 8'h01;
	localparam logic [2:0] RST_BAUD = 3'h0;
	localparam logic [15:0] HALT_BITS = 16'h0040;

	// fault types
	localparam logic [1:0] FT_NONE = 2'h0;
	localparam logic [1:0] FT_BREAK = 2'h1;
	localparam logic [1:0] FT_SHORT = 2'h2;

	// ==================================================
	// types
	typedef struct packed {
		logic [KIND_W-1:0] kind;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} clpm_msg_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} clpm_req_t;

	typedef enum logic [3:0] {
		S_IDLE = 4'b0001,
		S_SEND = 4'b0010,
		S_WAIT = 4'b0100,
		S_HALT = 4'b1000
	} clpm_state_t;

	typedef enum logic [2:0] {
		M_NORM = 3'b001,
		M_REC_A = 3'b010,
		M_REC_B = 3'b100
	} clpm_mode_t;

endpackage

/* File: clpm_master.sv */
`timescale 1ns/10ps
// Behaviour
// - poll every configured unit in a repeating scan; store each coded status reply
// - a pending command pauses the scan, goes first, then polling resumes in place
// - units report only new data; master acknowledges each report so it is not resent
// - every frame is checked for framing and crc; failing frames are dropped
// - no reply in time means up to three resends, then unit out of communication
// - normally port A transmits and receives, port B only monitors A's traffic
// - when port B loses A's traffic, stop transmitting; units fall into loopback
// - recovery addresses units one at a time from port A, lifting loopback
// - then port B becomes transceiver and repeats; all units reachable again
// - report fault type and the units adjacent to the fault
// - two answers at one address flag that address as duplicated
// - never send a command to a duplicated address
// - any unit parameter may be written remotely except its address
// - detect a unit that vanished while the rest keep talking
// - a setting chooses clearing a missing unit's data or keeping it
// - units report their type unasked; master stores it per unit
// - raising the upper address finds new units with no other setup
// - loop position is never assumed to follow address order
// - only a primary master drives the loop
// - up to 240 addressed units per loop
// - baud selectable from 110 to 2400, same on every unit
module clpm_master import clpm_pkg::*; #(
	parameter int CLK_HZ = 250_000_000,
	parameter logic [7:0] CRC_POLY = 8'h07
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// register port
	input wire clpm_req_t req,
	output logic [31:0] rdata,
	// redundancy role
	input wire logic primary,
	// loop ports
	input wire logic port_a_rx,
	output logic port_a_tx,
	input wire logic port_b_rx,
	output logic port_b_tx,
	output logic port_b_tx_en
);

	// ==================================================
	// configuration
	logic ctrl_en;
	logic ctrl_clr;
	logic [2:0] baud_sel;
	logic net_rst;
	logic [7:0] lo;
	logic [7:0] hi;
	logic [15:0] tmo;
	logic [7:0] unit_sel;
	logic [31:0] bit_cyc;

	// software writes land here; the upper address is clamped to the loop size
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_en <= 1'b0;
			ctrl_clr <= 1'b0;
			baud_sel <= RST_BAUD;
			net_rst <= 1'b0;
			lo <= RST_LO;
			hi <= RST_HI;
			tmo <= RST_TMO;
			unit_sel <= 8'h00;
		end else begin
			net_rst <= req.wr && req.addr == OFF_CTRL && req.wdata[CTRL_RESTART];
			if (req.wr) begin
				case (req.addr)
					OFF_CTRL: begin
						ctrl_en <= req.wdata[CTRL_EN];
						ctrl_clr <= req.wdata[CTRL_CLR];
						baud_sel <= req.wdata[CTRL_BAUD+:3];
					end
					OFF_RANGE: begin
						lo <= (req.wdata[7:0] == 8'h00) ? RST_LO : req.wdata[7:0];
						hi <= (req.wdata[15:8] > 8'(MAX_UNITS)) ? 8'(MAX_UNITS) : req.wdata[15:8];
					end
					OFF_TMO: tmo <= req.wdata[15:0];
					OFF_SEL: unit_sel <= req.wdata[7:0];
					default: ;
				endcase
			end
		end
	end

	// cycles per loop bit; one shared divisor for both ports
	always_comb begin
		case (baud_sel)
			3'h0: bit_cyc = 32'(CLK_HZ / BAUD_110);
			3'h1: bit_cyc = 32'(CLK_HZ / BAUD_300);
			3'h2: bit_cyc = 32'(CLK_HZ / BAUD_600);
			3'h3: bit_cyc = 32'(CLK_HZ / BAUD_1200);
			default: bit_cyc = 32'(CLK_HZ / BAUD_2400);
		endcase
	end

	// serial crc over the payload, msb-first feedback
	function automatic logic [CRC_W-1:0] crc_of(input logic [PAY_W-1:0] d);
		logic [CRC_W-1:0] c;
		c = '0;
		for (int i = 0; i < PAY_W; i++) begin
			if (c[CRC_W-1] ^ d[i])
				c = {c[CRC_W-2:0], 1'b0} ^ CRC_POLY;
			else
				c = {c[CRC_W-2:0], 1'b0};
		end
		return c;
	endfunction

	// ==================================================
	// receivers, index 0 is port A and 1 is port B
	logic rx_in [2];
	logic rx_busy [2];
	logic [31:0] rx_cnt [2];
	logic [4:0] rx_bit [2];
	logic [FRM_W-1:0] rx_sh [2];
	logic rx_vld [2];
	clpm_msg_t rx_msg [2];

	assign rx_in[0] = port_a_rx;
	assign rx_in[1] = port_b_rx;

	for (genvar g = 0; g < 2; g++) begin : g_rx
		// sample mid-bit; a start bit that is high again at mid-bit is a glitch
		always_ff @(posedge core_clk or negedge rst_n) begin
			if (!rst_n) begin
				rx_busy[g] <= 1'b0;
				rx_cnt[g] <= 32'h0000_0000;
				rx_bit[g] <= 5'h00;
				rx_sh[g] <= '0;
				rx_vld[g] <= 1'b0;
				rx_msg[g] <= '0;
			end else begin
				rx_vld[g] <= 1'b0;
				if (!rx_busy[g]) begin
					if (!rx_in[g]) begin
						rx_busy[g] <= 1'b1;
						rx_cnt[g] <= bit_cyc >> 1;
						rx_bit[g] <= 5'h00;
					end
				end else if (rx_cnt[g] != 32'h0000_0000) begin
					rx_cnt[g] <= rx_cnt[g] - 32'h0000_0001;
				end else begin
					rx_cnt[g] <= bit_cyc - 32'h0000_0001;
					rx_sh[g] <= {rx_in[g], rx_sh[g][FRM_W-1:1]};
					rx_bit[g] <= rx_bit[g] + 5'h01;
					if (rx_bit[g] == 5'h00 && rx_in[g])
						rx_busy[g] <= 1'b0;
					if (rx_bit[g] == 5'(FRM_W - 1)) begin
						rx_busy[g] <= 1'b0;
						rx_msg[g] <= rx_sh[g][PAY_W+1:2];
						// stop high, start low, crc good, else dropped
						rx_vld[g] <= rx_in[g] && !rx_sh[g][1]
							&& crc_of(rx_sh[g][PAY_W+1:2]) == rx_sh[g][FRM_W-1:PAY_W+2];
					end
				end
			end
		end
	end

	// ==================================================
	// scan and recovery control
	clpm_state_t state;
	clpm_mode_t mode;
	logic [7:0] cur;
	logic [7:0] rec_addr;
	logic [1:0] retry;
	logic [1:0] nrep;
	logic echo;
	logic use_b;
	logic tx_go;
	clpm_msg_t sent;
	clpm_msg_t rep;
	clpm_msg_t pick;
	logic pick_bad;
	logic [31:0] wcnt;
	logic [15:0] wbits;
	logic fault;
	logic [1:0] ftype;
	logic [7:0] adj_a;
	logic [7:0] adj_b;
	logic new_found;
	logic ack_pend;
	logic [7:0] ack_addr;
	logic cmd_pend;
	logic cmd_blk;
	logic cmd_param;
	logic [7:0] cmd_addr;
	logic [7:0] cmd_data;
	logic [255:0] present;
	logic [255:0] lost;
	logic [255:0] dup;
	logic [255:0] reach_a;
	logic [255:0] reach_b;
	logic [7:0] stat_mem [256];
	logic [3:0] type_mem [256];
	logic tx_idle;
	logic rx_hit;
	logic wait_end;

	assign rx_hit = rx_vld[use_b] && rx_msg[use_b].addr == sent.addr && rx_msg[use_b].kind[3];
	assign wait_end = wcnt == 32'h0000_0000 && wbits == 16'h0000;

	// next message: the recovery frame while recovering, else acknowledgement first, then command, then the scan
	always_comb begin
		pick = {K_POLL, cur, 8'h00};
		pick_bad = 1'b0;
		if (mode != M_NORM) begin
			pick = {K_LOOPOFF, rec_addr, 8'h00};
		end else if (ack_pend) begin
			pick = {K_ACK, ack_addr, 8'h00};
		end else if (cmd_pend) begin
			pick = {cmd_param ? K_PARAM : K_CMD, cmd_addr, cmd_data};
			pick_bad = dup[cmd_addr] || (cmd_param && cmd_data[7:4] == PARAM_ADDR_ID);
		end
	end

	// main sequencer; the scan pointer stays put while commands and acks go out
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= S_IDLE;
			mode <= M_NORM;
			cur <= RST_LO;
			rec_addr <= RST_LO;
			retry <= 2'h0;
			nrep <= 2'h0;
			echo <= 1'b0;
			use_b <= 1'b0;
			tx_go <= 1'b0;
			sent <= '0;
			rep <= '0;
			wcnt <= 32'h0000_0000;
			wbits <= 16'h0000;
			fault <= 1'b0;
			ftype <= FT_NONE;
			adj_a <= 8'h00;
			adj_b <= 8'h00;
			new_found <= 1'b0;
			ack_pend <= 1'b0;
			ack_addr <= 8'h00;
			cmd_pend <= 1'b0;
			cmd_blk <= 1'b0;
			cmd_param <= 1'b0;
			cmd_addr <= 8'h00;
			cmd_data <= 8'h00;
			present <= '0;
			lost <= '0;
			dup <= '0;
			reach_a <= '0;
			reach_b <= '0;
		end else begin
			tx_go <= 1'b0;
			// a write while a command is pending is ignored
			if (req.wr && req.addr == OFF_CMD && !cmd_pend) begin
				cmd_pend <= 1'b1;
				cmd_addr <= req.wdata[7:0];
				cmd_data <= req.wdata[15:8];
				cmd_param <= req.wdata[CMD_PARAM];
			end
			if (req.wr && req.addr == OFF_STAT && req.wdata[STAT_BLK])
				cmd_blk <= 1'b0;
			case (state)
				S_IDLE: begin
					if (primary && ctrl_en) begin
						if (pick_bad) begin
							cmd_pend <= 1'b0;
							cmd_blk <= 1'b1;
						end else begin
							sent <= pick;
							// after recovery a unit is served from whichever side reached it
							use_b <= (mode == M_REC_B) || (mode == M_NORM && fault && !reach_a[pick.addr]);
							tx_go <= 1'b1;
							nrep <= 2'h0;
							echo <= 1'b0;
							state <= S_SEND;
						end
					end
				end
				S_SEND: begin
					if (rx_vld[1] && rx_msg[1] == sent)
						echo <= 1'b1;
					if (tx_idle && !tx_go) begin
						wcnt <= bit_cyc - 32'h0000_0001;
						wbits <= tmo;
						state <= S_WAIT;
					end
				end
				S_WAIT: begin
					if (rx_vld[1] && rx_msg[1] == sent)
						echo <= 1'b1;
					if (rx_hit) begin
						rep <= rx_msg[use_b];
						if (nrep != 2'h3)
							nrep <= nrep + 2'h1;
					end
					if (wcnt != 32'h0000_0000) begin
						wcnt <= wcnt - 32'h0000_0001;
					end else if (wbits != 16'h0000) begin
						wcnt <= bit_cyc - 32'h0000_0001;
						wbits <= wbits - 16'h0001;
					end
					if (wait_end) begin
						if (mode == M_NORM && !fault && !echo) begin
							// port B lost our traffic: go silent so units drop into loopback
							fault <= 1'b1;
							reach_a <= '0;
							reach_b <= '0;
							new_found <= 1'b0;
							wcnt <= bit_cyc - 32'h0000_0001;
							wbits <= HALT_BITS;
							state <= S_HALT;
						end else if (nrep == 2'h0 && mode == M_NORM && retry != MAX_RETRY) begin
							retry <= retry + 2'h1;
							tx_go <= 1'b1;
							nrep <= 2'h0;
							echo <= 1'b0;
							state <= S_SEND;
						end else begin
							retry <= 2'h0;
							state <= S_IDLE;
							case (sent.kind)
								K_POLL: cur <= (cur >= hi || cur < lo) ? lo : cur + 8'h01;
								K_ACK: ack_pend <= 1'b0;
								K_CMD, K_PARAM: cmd_pend <= 1'b0;
								default: begin
									// each pass visits every address; repeat while new units appear
									if (rec_addr >= hi) begin
										rec_addr <= lo;
										new_found <= 1'b0;
										if (!new_found && mode == M_REC_A)
											mode <= M_REC_B;
										else if (!new_found)
											mode <= M_NORM;
									end else begin
										rec_addr <= rec_addr + 8'h01;
									end
								end
							endcase
							if (nrep == 2'h0 && mode == M_NORM) begin
								lost[sent.addr] <= 1'b1;
								present[sent.addr] <= 1'b0;
							end else if (nrep >= 2'h2) begin
								dup[sent.addr] <= 1'b1;
							end else if (nrep == 2'h1) begin
								present[sent.addr] <= 1'b1;
								lost[sent.addr] <= 1'b0;
								if (rep.kind == K_REPORT || rep.kind == K_TYPE) begin
									ack_pend <= 1'b1;
									ack_addr <= sent.addr;
								end
								if (mode == M_REC_A && !reach_a[sent.addr]) begin
									reach_a[sent.addr] <= 1'b1;
									adj_a <= sent.addr;
									new_found <= 1'b1;
								end
								if (mode == M_REC_B && !reach_b[sent.addr]) begin
									reach_b[sent.addr] <= 1'b1;
									adj_b <= sent.addr;
									new_found <= 1'b1;
								end
							end
						end
					end
				end
				S_HALT: begin
					if (wcnt != 32'h0000_0000) begin
						wcnt <= wcnt - 32'h0000_0001;
					end else if (wbits != 16'h0000) begin
						wcnt <= bit_cyc - 32'h0000_0001;
						wbits <= wbits - 16'h0001;
					end else begin
						// a line at space when the quiet time ends is a short, else a break
						ftype <= port_b_rx ? FT_BREAK : FT_SHORT;
						mode <= M_REC_A;
						rec_addr <= lo;
						state <= S_IDLE;
					end
				end
				default: state <= S_IDLE;
			endcase
			if (net_rst) begin
				fault <= 1'b0;
				ftype <= FT_NONE;
				mode <= M_NORM;
				state <= S_IDLE;
				present <= '0;
				lost <= '0;
				dup <= '0;
				cur <= lo;
			end
		end
	end

	// unit data store; kept as a plain array, so it holds no reset value
	always_ff @(posedge core_clk) begin
		if (state == S_WAIT && wait_end && nrep == 2'h1) begin
			if (rep.kind == K_REPORT)
				stat_mem[sent.addr] <= rep.data;
			if (rep.kind == K_TYPE)
				type_mem[sent.addr] <= rep.data[3:0];
		end else if (state == S_WAIT && wait_end && nrep == 2'h0 && retry == MAX_RETRY
				&& mode == M_NORM && fault && ctrl_clr) begin
			stat_mem[sent.addr] <= 8'h00;
		end else if (state == S_WAIT && wait_end && nrep == 2'h0 && retry == MAX_RETRY
				&& mode == M_NORM && echo && ctrl_clr) begin
			stat_mem[sent.addr] <= 8'h00;
		end
	end

	// ==================================================
	// transmitter; idle line is mark, the unused port stays at mark
	logic [FRM_W-1:0] tx_sh;
	logic [4:0] tx_left;
	logic [31:0] tx_cnt;

	assign tx_idle = tx_left == 5'h00 && tx_cnt == 32'h0000_0000;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_sh <= '0;
			tx_left <= 5'h00;
			tx_cnt <= 32'h0000_0000;
			port_a_tx <= 1'b1;
			port_b_tx <= 1'b1;
			port_b_tx_en <= 1'b0;
		end else begin
			port_b_tx_en <= primary && use_b;
			if (!primary) begin
				// a standby side drops the frame at once
				tx_left <= 5'h00;
				tx_cnt <= 32'h0000_0000;
				port_a_tx <= 1'b1;
				port_b_tx <= 1'b1;
			end else if (tx_go) begin
				tx_sh <= {1'b1, crc_of(sent), sent, 1'b0};
				tx_left <= 5'(FRM_W);
			end else if (tx_cnt != 32'h0000_0000) begin
				tx_cnt <= tx_cnt - 32'h0000_0001;
			end else if (tx_left != 5'h00) begin
				port_a_tx <= use_b ? 1'b1 : tx_sh[0];
				port_b_tx <= use_b ? tx_sh[0] : 1'b1;
				tx_sh <= tx_sh >> 1;
				tx_left <= tx_left - 5'h01;
				tx_cnt <= bit_cyc - 32'h0000_0001;
			end
		end
	end

	// ==================================================
	// register read, data valid only in the cycle after the strobe
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata <= 32'h0000_0000;
		end else if (req.rd) begin
			case (req.addr)
				OFF_CTRL: rdata <= {27'h000_0000, baud_sel, ctrl_clr, ctrl_en};
				OFF_RANGE: rdata <= {16'h0000, hi, lo};
				OFF_TMO: rdata <= {16'h0000, tmo};
				OFF_CMD: rdata <= {15'h0000, cmd_param, cmd_data, cmd_addr};
				OFF_STAT: rdata <= {4'h0, mode, state, cmd_pend, cmd_blk, fault, ftype, adj_b, adj_a};
				OFF_SEL: rdata <= {24'h00_0000, unit_sel};
				OFF_UNIT: rdata <= {15'h0000, reach_b[unit_sel], reach_a[unit_sel], dup[unit_sel],
					lost[unit_sel], present[unit_sel], type_mem[unit_sel], stat_mem[unit_sel]};
				default: rdata <= 32'h0000_0000;
			endcase
		end else begin
			rdata <= 32'h0000_0000;
		end
	end

endmodule

/* File: clpm_master_monitor.sv */
`timescale 1ns/10ps
// ====
// port checks for the loop polling master
module clpm_master_monitor import clpm_pkg::*; #(
	parameter int CLK_HZ = 250_000_000,
	parameter logic [7:0] CRC_POLY = 8'h07
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// register port
	input wire clpm_req_t req,
	input wire logic [31:0] rdata,
	// redundancy role
	input wire logic primary,
	// loop ports
	input wire logic port_a_rx,
	input wire logic port_a_tx,
	input wire logic port_b_rx,
	input wire logic port_b_tx,
	input wire logic port_b_tx_en
);
	logic en_m;
	logic [15:0] tmo_m;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	// ====
	// mirrors of the enable bit and the reply timeout
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			en_m <= 1'b0;
		else if (req.wr && req.addr == OFF_CTRL)
			en_m <= req.wdata[CTRL_EN];
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			tmo_m <= RST_TMO;
		else if (req.wr && req.addr == OFF_TMO)
			tmo_m <= req.wdata[15:0];
	end

	// ====
	// sequences
	sequence s_rd(logic [7:0] a);
		req.rd && req.addr == a;
	endsequence

	// eight clocks is one bit at 2400 baud; slower rates only hold longer
	sequence s_low;
		!port_a_tx [*8];
	endsequence

	// ====
	// assertions
	a_rdata_quiet: assert property (!$past(req.rd) |-> rdata == 32'h0000_0000)
		else $error("read data not zero outside a read");
	a_tmo_readback: assert property (s_rd(OFF_TMO) |=> rdata == {16'h0000, tmo_m})
		else $error("timeout reads back wrong");
	a_unmapped_zero: assert property (req.rd && req.addr > OFF_UNIT |=> rdata == 32'h0000_0000)
		else $error("unmapped read not zero");
	a_standby_mark: assert property (!primary ##1 !primary |-> port_a_tx && port_b_tx && !port_b_tx_en)
		else $error("standby master drives the loop");
	a_b_tx_gated: assert property (!port_b_tx_en |-> port_b_tx)
		else $error("port b moves while only a receiver");
	a_off_silent: assert property (!en_m ##1 !en_m |-> port_a_tx)
		else $error("loop traffic while disabled");
	a_bit_length: assert property (disable iff (!rst_n || !primary) $fell(port_a_tx) |-> s_low)
		else $error("low bit shorter than one bit period");
	a_tx_needs_en: assert property ($fell(port_a_tx) |-> en_m && $past(primary))
		else $error("frame started without enable or role");
endmodule

bind clpm_master clpm_master_monitor #(.CLK_HZ(CLK_HZ), .CRC_POLY(CRC_POLY)) mon_u (.core_clk(core_clk),
	.rst_n(rst_n), .req(req), .rdata(rdata), .primary(primary), .port_a_rx(port_a_rx),
	.port_a_tx(port_a_tx), .port_b_rx(port_b_rx), .port_b_tx(port_b_tx), .port_b_tx_en(port_b_tx_en));

/* File: clpm_unit_model.sv */
`timescale 1ns/10ps
// ====
// field units on the loop, answering on port a
module clpm_unit_model import clpm_pkg::*; #(
	parameter int BIT_CYC = 8,
	parameter logic [7:0] CRC_POLY = 8'h07
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// scenario controls
	input wire logic [3:0] alive,
	input wire logic dup1,
	input wire logic brk,
	input wire logic [7:0] salt,
	// loop wires
	input wire logic tx,
	output logic rx = 1'b1,
	output logic b_rx,
	output clpm_msg_t seen
);
	logic [3:0] typed = 4'h0;
	logic [3:0] fresh = 4'hf;
	logic [3:0] lastk [4];

	// unpowered units bypass, so traffic still reaches port b; a break leaves it at mark
	assign b_rx = brk | (tx & rx);

	function automatic logic [7:0] crc(input logic [19:0] p);
		logic [7:0] c = 8'h00;
		for (int i = 0; i < 20; i++)
			c = {c[6:0], 1'b0} ^ ((c[7] ^ p[i]) ? CRC_POLY : 8'h00);
		return c;
	endfunction

	// frame out, lsb first; the stop bit leaves the line at mark, so two replies chain with one drive per step
	task automatic send(input clpm_msg_t m);
		logic [29:0] f;
		f = {1'b1, crc(m), m, 1'b0};
		for (int i = 0; i < 30; i++) begin
			rx <= f[i];
			repeat (BIT_CYC) @(posedge core_clk);
		end
	endtask

	// units speak only after a valid master frame addressed to them
	always begin : rx_loop
		logic [29:0] f;
		clpm_msg_t m;
		int u;
		@(negedge tx iff rst_n);
		repeat (BIT_CYC / 2) @(posedge core_clk);
		for (int i = 0; i < 30; i++) begin
			f[i] = tx;
			repeat (BIT_CYC) @(posedge core_clk);
		end
		m = f[20:1];
		u = int'(m.addr) - 1;
		if (!f[0] && f[29] && f[28:21] == crc(m) && u >= 0 && u < 4 && alive[u]) begin
			if (m.kind == K_ACK && lastk[u] == K_TYPE) typed[u] = 1'b1;
			if (m.kind == K_ACK && lastk[u] == K_REPORT) fresh[u] = 1'b0;
			if (m.kind == K_CMD || m.kind == K_PARAM) seen <= m;
			lastk[u] = m.kind != K_POLL ? K_NONEW : !typed[u] ? K_TYPE : fresh[u] ? K_REPORT : K_NONEW;
			repeat (BIT_CYC) @(posedge core_clk);
			repeat (1 + (dup1 && u == 0))
				send({lastk[u], m.addr, lastk[u] == K_TYPE ? {4'h0, m.addr[3:0] + 4'h4} : salt ^ m.addr});
		end
	end
endmodule

/* File: current_loop_poll_master_test.sv */
`timescale 1ns/10ps
// ====
// bench for the loop polling master
module current_loop_poll_master_test;
	import clpm_pkg::*;
	// eight clocks a bit at 2400 baud keeps the run short
	localparam int CLK_HZ = 19200;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	clpm_req_t req = '0;
	logic [31:0] rdata;
	logic primary = 1'b1;
	logic port_a_rx, port_a_tx, port_b_rx, port_b_tx, port_b_tx_en;
	logic [3:0] alive = 4'h7;
	logic dup1 = 1'b0;
	logic brk = 1'b0;
	logic [7:0] salt = 8'h00;
	clpm_msg_t seen;
	int errors = 0;
	int n_compared = 0;
	logic [31:0] d;
	logic [7:0] r;

	always #2 core_clk = ~core_clk;

	clpm_master #(.CLK_HZ(CLK_HZ), .CRC_POLY(8'h07)) dut_u (.core_clk(core_clk), .rst_n(rst_n), .req(req),
		.rdata(rdata), .primary(primary), .port_a_rx(port_a_rx), .port_a_tx(port_a_tx),
		.port_b_rx(port_b_rx), .port_b_tx(port_b_tx), .port_b_tx_en(port_b_tx_en));
	clpm_unit_model #(.BIT_CYC(CLK_HZ / 2400), .CRC_POLY(8'h07)) unit_u (.core_clk(core_clk), .rst_n(rst_n),
		.alive(alive), .dup1(dup1), .brk(brk), .salt(salt), .tx(port_a_tx), .rx(port_a_rx),
		.b_rx(port_b_rx), .seen(seen));

	// ====
	// register access, one idle cycle after each so strobes never re-assert in one step
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
		@(posedge core_clk);
		req <= '0;
		@(posedge core_clk);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		req <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
		@(posedge core_clk);
		req <= '0;
		#1 v = rdata;
		@(posedge core_clk);
	endtask

	task automatic report_and_stop();
		if (errors == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("BAD %0t seen %h expected %h", $time, got, exp);
		end
	endtask

	// poll a register until the masked field matches, bounded
	task automatic wait_for(input logic [7:0] a, input logic [7:0] u, input logic [31:0] m, input logic [31:0] v);
		int k;
		for (k = 0; k < 60; k++) begin
			if (a == OFF_UNIT) wr(OFF_SEL, {24'h00_0000, u});
			rd(a, d);
			if ((d & m) === v) break;
			repeat (300) @(posedge core_clk);
		end
		chk(d & m, v);
		if (k == 60) report_and_stop();
	endtask

	task automatic wait_seen(input clpm_msg_t m);
		int k;
		for (k = 0; k < 40 && seen !== m; k++) repeat (200) @(posedge core_clk);
		chk({12'h000, seen}, {12'h000, m});
		if (k == 40) report_and_stop();
	endtask

	// no dup, no loss, present, type, status
	function automatic logic [31:0] exp_unit(input logic [7:0] a);
		return {17'h0_0000, 3'b001, a[3:0] + 4'h4, salt ^ a};
	endfunction

	// ====
	// main sequence
	initial begin
		void'($urandom(32'hdaeaa59f));
		repeat (8) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		salt <= 8'($urandom);
		r = 8'($urandom);
		rd(OFF_CTRL, d);
		chk(d, 32'h0000_0000);
		rd(OFF_RANGE, d);
		chk(d, {16'h0000, RST_HI, RST_LO});
		rd(OFF_TMO, d);
		chk(d, {16'h0000, RST_TMO});
		rd(8'h1c, d);
		chk(d, 32'h0000_0000);
		// low of zero becomes one, high clamps at the unit limit
		wr(OFF_RANGE, 32'h0000_ff00);
		rd(OFF_RANGE, d);
		chk(d, 32'h0000_f001);
		wr(OFF_RANGE, 32'h0000_0301);
		wr(OFF_TMO, 32'h0000_0050);
		wr(OFF_CTRL, 32'h0000_0013);
		for (int a = 1; a < 4; a++)
			wait_for(OFF_UNIT, a[7:0], 32'h0000_7fff, exp_unit(a[7:0]));
		// command jumps the scan, then parameter writes
		wr(OFF_CMD, {15'h0000, 1'b0, r, 8'h02});
		rd(OFF_STAT, d);
		chk(d & 32'h0010_0000, 32'h0010_0000);
		wait_seen({K_CMD, 8'h02, r});
		wait_for(OFF_STAT, 8'h00, 32'h0010_0000, 32'h0000_0000);
		wr(OFF_CMD, {15'h0000, 1'b1, 4'h3, r[3:0], 8'h02});
		wait_seen({K_PARAM, 8'h02, 4'h3, r[3:0]});
		wait_for(OFF_STAT, 8'h00, 32'h0010_0000, 32'h0000_0000);
		wr(OFF_CMD, {15'h0000, 1'b1, PARAM_ADDR_ID, r[3:0], 8'h02});
		wait_for(OFF_STAT, 8'h00, 32'h0008_0000, 32'h0008_0000);
		wr(OFF_STAT, 32'h0008_0000);
		rd(OFF_STAT, d);
		chk(d & 32'h0008_0000, 32'h0000_0000);
		// raise the top address, a fourth unit joins
		wr(OFF_RANGE, 32'h0000_0401);
		alive <= 4'hf;
		wait_for(OFF_UNIT, 8'h04, 32'h0000_7fff, exp_unit(8'h04));
		// two answers at address one
		dup1 <= 1'b1;
		wait_for(OFF_UNIT, 8'h01, 32'h0000_4000, 32'h0000_4000);
		wr(OFF_CMD, {15'h0000, 1'b0, r, 8'h01});
		wait_for(OFF_STAT, 8'h00, 32'h0008_0000, 32'h0008_0000);
		chk({12'h000, seen}, {12'h000, K_PARAM, 8'h02, 4'h3, r[3:0]});
		// unit three loses power
		alive <= 4'hb;
		wait_for(OFF_UNIT, 8'h03, 32'h0000_30ff, 32'h0000_2000);
		// unit four loses power with clearing off, so its last status is kept
		wr(OFF_CTRL, 32'h0000_0011);
		alive <= 4'h3;
		wait_for(OFF_UNIT, 8'h04, 32'h0000_30ff, {18'h0_0000, 2'b10, 4'h0, salt ^ 8'h04});
		// cable break ahead of port b
		brk <= 1'b1;
		wait_for(OFF_STAT, 8'h00, 32'h0007_0000, {13'h0000, 1'b1, FT_BREAK, 16'h0000});
		// both passes end in normal mode; only unit two is reached from port a, none from port b
		wait_for(OFF_STAT, 8'h00, 32'h0e07_ffff, {4'h0, M_NORM, 4'h0, 3'b001, FT_BREAK, 16'h0002});
		// standby role, the checker watches the lines
		primary <= 1'b0;
		repeat (2000) @(posedge core_clk);
		primary <= 1'b1;
		@(posedge core_clk);
		report_and_stop();
	end
endmodule
